// file: hw/umc_params.svh
// register offsets, field positions, reset values and timing counts of the usb module control
`ifndef UMC_PARAMS_SVH
`define UMC_PARAMS_SVH

// word indexes on the avalon slave (byte address is four times these)
`define UMC_REG_CONTROL     3'h0
`define UMC_REG_CONFIG      3'h1
`define UMC_REG_IRQ_STATUS  3'h2
`define UMC_REG_IRQ_MASK    3'h3
`define UMC_REG_PP_POINTERS 3'h4
`define UMC_REG_XFER_STATUS 3'h5

// usb_control field positions
`define UMC_CTL_PP_RESET    6
`define UMC_CTL_SE0         5
`define UMC_CTL_PKT_DIS     4
`define UMC_CTL_ENABLE      3
`define UMC_CTL_RESUME      2
`define UMC_CTL_SUSPEND     1

// usb_configuration field positions
`define UMC_CFG_PP_LO       0
`define UMC_CFG_PP_HI       1
`define UMC_CFG_FULL_SPEED  2
`define UMC_CFG_PULLUP      4
`define UMC_CFG_REGULATOR   5

// interrupt status and mask bit positions
`define UMC_IRQ_SETUP       0
`define UMC_IRQ_IDLE        1
`define UMC_IRQ_ACTIVITY    2
`define UMC_IRQ_RESUME_DONE 3
`define UMC_IRQ_SE0_START   4
`define UMC_IRQ_WIDTH       5

// values
`define UMC_PP_MODE_OFF     2'h0
`define UMC_RESET_BYTE      8'h00
`define UMC_EP_COUNT        16

// resume timing: 10 ms at 125 MHz
`define UMC_RESUME_MS       10
`define UMC_CLK_KHZ         125000
`define UMC_RESUME_CYCLES   (`UMC_RESUME_MS * `UMC_CLK_KHZ)
`define UMC_RESUME_CW       21

`endif

// file: hw/umc_pkg.sv
// types shared by the usb module control design files
package umc_pkg;
  // avalon slave answer sequence
  typedef enum logic {
    UMC_BUS_WAIT,
    UMC_BUS_ANSWER
  } umc_bus_e;
  // one register byte lane
  typedef logic [7:0] umc_byte_t;
endpackage

// file: hw/umc_pin_if.sv
// raw and filtered bus line levels between the top and its input filter
`timescale 1ns/1ns
interface umc_pin_if;
  logic [1:0] raw;   // {dp, dm} straight from the pins
  logic [1:0] level; // {dp, dm} after three flops and agreement
  modport filter (input raw, output level);
  modport user   (output raw, input level);
endinterface

// file: hw/umc_pin_filter.sv
// three-flop synchroniser with agreement filter for the bus data lines
`timescale 1ns/1ns
module umc_pin_filter
  import umc_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic clk_en,
  umc_pin_if.filter pins
);

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_line
      logic s1; // first stage, read only by s2
      logic s2; // second stage
      logic s3; // third stage
      logic lv; // accepted level

      // shift chain; a change counts once stage two and three agree
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          lv <= 1'b0;
        end else if (clk_en) begin
          s1 <= pins.raw[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            lv <= s3;
          end
        end
      end

      assign pins.level[i] = lv;
    end
  endgenerate

endmodule

// file: hw/umc_top.sv
// usb module control: control register, attach, ping-pong reset, suspend, resume and interrupts
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "umc_params.svh"
// Overview of operation
// - control bit 5 shows live single-ended zero
// - setting enable activates module, clears pointer bits
// - enable switches regulator and pull-ups: soft attach
// - disabled module ignores every other control bit except a packet disable clear
// - pointer reset bit holds pointers even, sticky
// - pointer reset ignored without ping-pong buffering
// - setup token sets packet disable, halts processing
// - software may only clear packet disable
// - pending transfer events stay readable while halted
// - resume bit drives resume signalling; 10 ms
// - suspend: low power, sie clock stopped
// - suspended device stays attached, outputs idle
// - ping-pong mode 00 disables ping-pong buffering; here mode 00 only blocks the pointer reset, toggles still flip the pointers
module umc_top
  import umc_pkg::*;
#(
  parameter int unsigned RESUME_CYCLES = `UMC_RESUME_CYCLES // resume hold time in cycles
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        dp_in,
  input  wire logic        dm_in,
  output logic             dp_out,
  output logic             dm_out,
  output logic             tx_oe_n,
  input  wire logic        setup_token,
  input  wire logic        bus_idle_event,
  input  wire logic        bus_activity_event,
  input  wire logic [15:0] pingpong_pointer_bit_toggle,
  input  wire logic        status_fifo_pending,
  output logic             module_enable,
  output logic             packet_processing_disable,
  output logic [15:0]      pingpong_pointer_bit,
  output logic             regulator_on,
  output logic             regulator_low_power,
  output logic             pullup_connect,
  output logic             sie_clock_enable,
  output logic             irq
);

  // true when the word address selects the given register
  function automatic logic hit(input logic [2:0] addr, input logic [2:0] idx);
    hit = (addr == idx);
  endfunction

  umc_bus_e                    bus_state;           // slave answer sequence
  logic                        pingpong_pointer_reset; // sticky pointer reset request
  logic                        resume_request;      // resume signalling request
  logic                        suspend_request;     // suspend request
  logic [1:0]                  pingpong_mode_field; // ping-pong configuration
  logic                        full_speed;          // speed select, sets j/k polarity
  logic                        pullup_enable;       // internal pull-up option
  logic                        regulator_config_enable; // regulator option
  logic [`UMC_IRQ_WIDTH-1:0]   irq_status;          // sticky events
  logic [`UMC_IRQ_WIDTH-1:0]   irq_mask;            // event gate
  logic [`UMC_IRQ_WIDTH-1:0]   irq_event;           // this cycle's events
  logic [`UMC_RESUME_CW-1:0]   resume_count;        // cycles of resume held
  logic                        resume_elapsed;      // resume held long enough
  logic                        se0_live;            // both lines low, filtered
  logic                        se0_prev;            // se0 one cycle back
  logic                        wr_acc;              // write takes effect now
  logic                        wr_lane0;            // write with low byte enabled
  logic                        en_set;              // enable rising by this write
  logic                        driving;             // resume being driven
  logic [`UMC_RESUME_CW-1:0]   resume_limit;        // cycle budget, narrowed
  logic [31:0]                 read_mux;            // selected read word
  umc_byte_t                   wbyte;               // low write byte
  umc_pin_if                   pins ();             // line levels to and from the filter

  assign resume_limit = RESUME_CYCLES[`UMC_RESUME_CW-1:0];
  assign wbyte        = avs_writedata[7:0];
  assign pins.raw     = {dp_in, dm_in};

  // lines come from outside the clock domain, so they pass the filter first
  umc_pin_filter u_filter (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .pins   (pins)
  );

  // ---------------- avalon slave ----------------
  // a request is answered one cycle later; waitrequest drops for exactly that cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_state       <= UMC_BUS_WAIT;
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      case (bus_state)
        UMC_BUS_WAIT: begin
          if (avs_read || avs_write) begin
            bus_state       <= UMC_BUS_ANSWER;
            avs_waitrequest <= 1'b0;
          end
        end
        UMC_BUS_ANSWER: begin
          bus_state       <= UMC_BUS_WAIT; // master releases after this edge
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state       <= UMC_BUS_WAIT;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // writes land at the edge where the master sees waitrequest low
  assign wr_acc   = (bus_state == UMC_BUS_ANSWER) && avs_write;
  assign wr_lane0 = wr_acc && avs_byteenable[0];
  assign en_set   = wr_lane0 && hit(avs_address, `UMC_REG_CONTROL)
                    && wbyte[`UMC_CTL_ENABLE] && !module_enable;

  // read word; unmapped addresses and unimplemented bits read zero
  always_comb begin
    read_mux = 32'h0000_0000;
    case (avs_address)
      `UMC_REG_CONTROL: begin
        read_mux[`UMC_CTL_PP_RESET] = pingpong_pointer_reset;
        read_mux[`UMC_CTL_SE0]      = se0_live;
        read_mux[`UMC_CTL_PKT_DIS]  = packet_processing_disable;
        read_mux[`UMC_CTL_ENABLE]   = module_enable;
        read_mux[`UMC_CTL_RESUME]   = resume_request;
        read_mux[`UMC_CTL_SUSPEND]  = suspend_request;            // bits 7 and 0 stay 0
      end
      `UMC_REG_CONFIG: begin
        read_mux[`UMC_CFG_PP_HI:`UMC_CFG_PP_LO] = pingpong_mode_field;
        read_mux[`UMC_CFG_FULL_SPEED]           = full_speed;
        read_mux[`UMC_CFG_PULLUP]               = pullup_enable;
        read_mux[`UMC_CFG_REGULATOR]            = regulator_config_enable;
      end
      `UMC_REG_IRQ_STATUS:  read_mux[`UMC_IRQ_WIDTH-1:0] = irq_status;
      `UMC_REG_IRQ_MASK:    read_mux[`UMC_IRQ_WIDTH-1:0] = irq_mask;
      `UMC_REG_PP_POINTERS: read_mux[15:0] = pingpong_pointer_bit;
      `UMC_REG_XFER_STATUS: begin
        read_mux[0] = status_fifo_pending; // never flushed by the halt
        read_mux[1] = resume_elapsed;
      end
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // read data captured when the answer starts and held until the next read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (bus_state == UMC_BUS_WAIT && avs_read) begin
        avs_readdata <= read_mux;
      end
    end
  end

  // ---------------- control register ----------------
  // plain read/write bits; se0 and the unimplemented bits have no storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pingpong_pointer_reset <= 1'b0;
      module_enable          <= 1'b0;
      resume_request         <= 1'b0;
      suspend_request        <= 1'b0;
    end else if (clk_en) begin
      if (wr_lane0 && hit(avs_address, `UMC_REG_CONTROL)) begin
        pingpong_pointer_reset <= wbyte[`UMC_CTL_PP_RESET]; // stays until firmware clears
        module_enable          <= wbyte[`UMC_CTL_ENABLE];   // soft attach / detach
        resume_request         <= wbyte[`UMC_CTL_RESUME];
        suspend_request        <= wbyte[`UMC_CTL_SUSPEND];  // firmware times it
      end
    end
  end

  // packet halt: hardware sets on setup, software can only clear; set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      packet_processing_disable <= 1'b0;
    end else if (clk_en) begin
      if (module_enable && setup_token) begin
        packet_processing_disable <= 1'b1;
      end else if (wr_lane0 && hit(avs_address, `UMC_REG_CONTROL)
                   && !wbyte[`UMC_CTL_PKT_DIS]) begin
        packet_processing_disable <= 1'b0;
      end
    end
  end

  // configuration bits; meant to be set before enabling, not while running
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pingpong_mode_field     <= `UMC_PP_MODE_OFF;
      full_speed              <= 1'b0;
      pullup_enable           <= 1'b0;
      regulator_config_enable <= 1'b0;
    end else if (clk_en) begin
      if (wr_lane0 && hit(avs_address, `UMC_REG_CONFIG)) begin
        pingpong_mode_field     <= wbyte[`UMC_CFG_PP_HI:`UMC_CFG_PP_LO];
        full_speed              <= wbyte[`UMC_CFG_FULL_SPEED];
        pullup_enable           <= wbyte[`UMC_CFG_PULLUP];
        regulator_config_enable <= wbyte[`UMC_CFG_REGULATOR];
      end
    end
  end

  // ---------------- ping-pong pointers ----------------
  // enable rising clears all; reset bit holds them even only in ping-pong modes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pingpong_pointer_bit <= 16'h0000;
    end else if (clk_en) begin
      if (en_set) begin
        pingpong_pointer_bit <= 16'h0000;
      end else if (module_enable && pingpong_pointer_reset
                   && pingpong_mode_field != `UMC_PP_MODE_OFF) begin
        pingpong_pointer_bit <= 16'h0000;
      end else if (module_enable && !packet_processing_disable) begin
        pingpong_pointer_bit <= pingpong_pointer_bit ^ pingpong_pointer_bit_toggle;
      end
    end
  end

  // ---------------- resume timing ----------------
  // counts how long resume is held so firmware can see the 10 ms mark
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resume_count <= '0;
    end else if (clk_en) begin
      if (!(module_enable && resume_request)) begin
        resume_count <= '0;
      end else if (resume_count != resume_limit) begin
        resume_count <= resume_count + 1'b1; // saturates, no wrap
      end
    end
  end

  assign resume_elapsed = (resume_count == resume_limit);

  // ---------------- line status ----------------
  // se0 reflected whether or not the module is enabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      se0_live <= 1'b0;
      se0_prev <= 1'b0;
    end else if (clk_en) begin
      se0_live <= (pins.level == 2'b00);
      se0_prev <= se0_live;
    end
  end

  // ---------------- interrupts ----------------
  // events are only recognised while enabled
  always_comb begin
    irq_event = '0;
    if (module_enable) begin
      irq_event[`UMC_IRQ_SETUP]       = setup_token;
      irq_event[`UMC_IRQ_IDLE]        = bus_idle_event;
      irq_event[`UMC_IRQ_ACTIVITY]    = bus_activity_event;
      irq_event[`UMC_IRQ_RESUME_DONE] = resume_request && (resume_count == resume_limit - 1'b1);
      irq_event[`UMC_IRQ_SE0_START]   = se0_live && !se0_prev;
    end
  end

  // write one to clear; an event in the clearing cycle survives
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else if (clk_en) begin
      if (wr_lane0 && hit(avs_address, `UMC_REG_IRQ_STATUS)) begin
        irq_status <= (irq_status & ~wbyte[`UMC_IRQ_WIDTH-1:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
      if (wr_lane0 && hit(avs_address, `UMC_REG_IRQ_MASK)) begin
        irq_mask <= wbyte[`UMC_IRQ_WIDTH-1:0];
      end
    end
  end

  // ---------------- module outputs ----------------
  // resume drives k; suspend forces idle j with driver off
  assign driving = module_enable && resume_request && !suspend_request;

  // all derived outputs registered, one cycle behind their causes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regulator_on        <= 1'b0;
      regulator_low_power <= 1'b0;
      pullup_connect      <= 1'b0;
      sie_clock_enable    <= 1'b0;
      tx_oe_n             <= 1'b1;
      dp_out              <= 1'b0;
      dm_out              <= 1'b0;
      irq                 <= 1'b0;
    end else if (clk_en) begin
      regulator_on        <= module_enable && regulator_config_enable;
      regulator_low_power <= module_enable && regulator_config_enable
                             && suspend_request;
      pullup_connect      <= module_enable && pullup_enable;
      sie_clock_enable    <= module_enable && !suspend_request;
      tx_oe_n             <= !driving;
      dp_out              <= full_speed ^ driving;  // j: dp high at full speed
      dm_out              <= !full_speed ^ driving;
      irq                 <= |(irq_status & irq_mask);
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk iff clk_en); endclocking
  default disable iff (!arst_n);

  se0_read_a: assert property ((bus_state == UMC_BUS_WAIT) && avs_read
      && avs_address == `UMC_REG_CONTROL |=> avs_readdata[5] == $past(se0_live))
    else $error("se0 flag read wrong");
  pp_enable_a: assert property (en_set |=> pingpong_pointer_bit == 16'h0000)
    else $error("pointers not cleared on enable");
  pp_reset_a: assert property (module_enable && pingpong_pointer_reset
      && pingpong_mode_field != 2'h0 |=> pingpong_pointer_bit == 16'h0000)
    else $error("pointer reset ignored");
  pp_ignore_a: assert property (pingpong_mode_field == 2'h0 && !en_set
      && pingpong_pointer_bit_toggle == 16'h0000 |=> $stable(pingpong_pointer_bit))
    else $error("pointer reset acted without ping-pong");
  setup_lock_a: assert property (module_enable && setup_token
      |=> packet_processing_disable [*1] ##1 1)
    else $error("setup did not halt packets");
  pkt_noset_a: assert property (!packet_processing_disable
      && !(module_enable && setup_token) |=> !packet_processing_disable)
    else $error("packet disable set by software");
  resume_drive_a: assert property (driving |=> !tx_oe_n && dp_out == !full_speed)
    else $error("resume not driven");
  suspend_idle_a: assert property (module_enable && suspend_request
      |=> !sie_clock_enable && tx_oe_n)
    else $error("suspend did not stop clock");
  disabled_quiet_a: assert property (!module_enable |=> !sie_clock_enable
      && !regulator_on && !pullup_connect && tx_oe_n)
    else $error("disabled module active");
  unimpl_zero_a: assert property ((bus_state == UMC_BUS_WAIT) && avs_read
      && avs_address == `UMC_REG_CONTROL
      |=> avs_readdata[7] == 1'b0 && avs_readdata[0] == 1'b0)
    else $error("unimplemented bit read one");
  bus_answer_a: assert property ((bus_state == UMC_BUS_WAIT) && (avs_read || avs_write)
      |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

  setup_seen_c:   cover property (module_enable && setup_token ##[1:20] !packet_processing_disable);
  resume_done_c:  cover property (irq_event[`UMC_IRQ_RESUME_DONE]);
  suspend_c:      cover property (module_enable && suspend_request ##1 !sie_clock_enable);
  pp_reset_c:     cover property (module_enable && pingpong_pointer_reset && pingpong_pointer_bit_toggle != 0);

endmodule

// file: verification/umc_host_model.sv
// host side of the usb data lines for the module control bench
`timescale 1ns/1ns
module umc_host_model (
  input  wire logic dp_out,
  input  wire logic dm_out,
  input  wire logic tx_oe_n,
  output logic      dp_in,
  output logic      dm_in
);
  logic se0; // host pulls both lines low when set

  initial se0 = 1'b0;

  // host reset signalling on or off
  task automatic drive_se0(input logic on);
    se0 = on;
  endtask

  // device driver wins while enabled; else pull-up on dp gives idle j
  always_comb begin
    if (!tx_oe_n) begin
      dp_in = dp_out;
      dm_in = dm_out;
    end else begin
      dp_in = ~se0;
      dm_in = 1'b0;
    end
  end
endmodule

// file: verification/umc_top_test.sv
// self-checking bench of the usb module control block
`timescale 1ns/1ns
module umc_top_test;
  import umc_pkg::*;
  logic        clk, arst_n, rd, wr, fifo, ce;
  logic [2:0]  adr, ev;        // ev: setup, idle, activity pulses
  logic [31:0] wdat, rdat, got;
  logic [15:0] tog, ptr;
  logic        wreq, dp_i, dm_i, dp_o, dm_o, oe_n;
  logic        men, pkd, reg_on, reg_lp, pu, sce, irq;
  int          miscompares, n_tests;

  umc_top #(.RESUME_CYCLES(20)) u_dut (
    .clk(clk), .arst_n(arst_n), .clk_en(ce), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'h1), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .dp_in(dp_i), .dm_in(dm_i), .dp_out(dp_o), .dm_out(dm_o),
    .tx_oe_n(oe_n), .setup_token(ev[0]), .bus_idle_event(ev[1]),
    .bus_activity_event(ev[2]), .pingpong_pointer_bit_toggle(tog), .status_fifo_pending(fifo),
    .module_enable(men), .packet_processing_disable(pkd), .pingpong_pointer_bit(ptr),
    .regulator_on(reg_on), .regulator_low_power(reg_lp), .pullup_connect(pu),
    .sie_clock_enable(sce), .irq(irq));

  umc_host_model u_host (.dp_out(dp_o), .dm_out(dm_o), .tx_oe_n(oe_n),
    .dp_in(dp_i), .dm_in(dm_i));

  // one comparison, counted
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // avalon transfer; values read right after the edge are the sampled ones
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    adr <= a;
    wdat <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    got = rdat;
    check("waitrequest", 16'h0, {15'h0, wreq});
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk); // gap so the next request is not set in this step
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [15:0] exp, input string what);
    bus(1'b0, a, 8'h00);
    check(what, exp, got[15:0]);
  endtask

  // one-cycle sie pulses
  task automatic pulse(input logic [2:0] e, input logic [15:0] t);
    ev <= e;
    tog <= t;
    @(posedge clk);
    ev <= 3'h0;
    tog <= 16'h0;
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // reserved bits, se0 flag and an unmapped index
  task automatic t_bits;
    bus(1'b1, 3'h0, 8'ha1);
    rdchk(3'h0, 16'h0, "control");
    rdchk(3'h7, 16'h0, "unmapped");
    u_host.drive_se0(1'b1);
    idle(8);
    rdchk(3'h0, 16'h20, "se0 on");
    u_host.drive_se0(1'b0);
    idle(8);
    rdchk(3'h0, 16'h0, "se0 off");
  endtask

  // soft attach and pointer handling
  task automatic t_attach;
    bus(1'b1, 3'h1, 8'h35);
    bus(1'b1, 3'h0, 8'h08);
    idle(2);
    check("attach", 16'h7, {13'h0, men, reg_on, pu});
    pulse(3'h0, 16'h8001);
    rdchk(3'h4, 16'h8001, "toggle");
    bus(1'b1, 3'h0, 8'h48);
    pulse(3'h0, 16'h0001);
    rdchk(3'h4, 16'h0, "pp reset");
    bus(1'b1, 3'h0, 8'h08);
    pulse(3'h0, 16'h0002);
    bus(1'b1, 3'h1, 8'h34);
    bus(1'b1, 3'h0, 8'h48);
    rdchk(3'h4, 16'h2, "mode off");
    bus(1'b1, 3'h0, 8'h08);
    bus(1'b1, 3'h1, 8'h35);
    bus(1'b1, 3'h0, 8'h00);
    bus(1'b1, 3'h0, 8'h08);
    rdchk(3'h4, 16'h0, "enable clr");
  endtask

  // clock enable low: a toggle pulse must not reach the pointers
  task automatic t_freeze;
    ce <= 1'b0;
    pulse(3'h0, 16'h0010);
    ce <= 1'b1;
    rdchk(3'h4, 16'h0, "frozen ptr");
  endtask

  // setup lock, clear-only bit, interrupt raise and clear
  task automatic t_setup;
    bus(1'b1, 3'h3, 8'h01);
    bus(1'b1, 3'h0, 8'h18);
    rdchk(3'h0, 16'h08, "packet_processing_disable set");
    fifo <= 1'b1;
    pulse(3'h1, 16'h0);
    idle(2);
    check("lock", 16'h3, {14'h0, pkd, irq});
    pulse(3'h0, 16'h0004);
    rdchk(3'h4, 16'h0, "halted");
    rdchk(3'h5, 16'h1, "pending");
    bus(1'b1, 3'h0, 8'h18);
    rdchk(3'h0, 16'h18, "packet_processing_disable keep");
    bus(1'b1, 3'h2, 8'h01);
    idle(2);
    check("irq clr", 16'h0, {15'h0, irq});
    bus(1'b1, 3'h0, 8'h08);
    rdchk(3'h0, 16'h08, "packet_processing_disable clr");
    fifo <= 1'b0;
    bus(1'b1, 3'h0, 8'h00);
    pulse(3'h1, 16'h0);
    rdchk(3'h0, 16'h0, "dis ctl");
    rdchk(3'h2, 16'h0, "dis irq");
    bus(1'b1, 3'h0, 8'h08);
  endtask

  // remote wake-up, then suspend with idle and activity events
  task automatic t_power;
    bus(1'b1, 3'h0, 8'h0c);
    idle(2);
    check("resume", 16'h1, {13'h0, oe_n, dp_o, dm_o});
    idle(25);
    rdchk(3'h5, 16'h2, "elapsed");
    rdchk(3'h2, 16'h8, "resume irq");
    bus(1'b1, 3'h2, 8'h08);
    bus(1'b1, 3'h0, 8'h08);
    idle(2);
    check("idle j", 16'h6, {13'h0, oe_n, dp_o, dm_o});
    pulse(3'h2, 16'h0);
    bus(1'b1, 3'h0, 8'h0e);
    idle(2);
    check("suspend", 16'h0e, {11'h0, sce, reg_lp, pu, oe_n, irq});
    pulse(3'h4, 16'h0);
    bus(1'b1, 3'h0, 8'h08);
    idle(2);
    check("wake", 16'h1, {15'h0, sce});
    bus(1'b1, 3'h0, 8'h00);
  endtask

  task automatic conclude;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard, far beyond the few hundred cycles the tests take
  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  initial begin
    arst_n = 1'b0;
    {rd, wr, fifo, adr, ev, wdat, tog} = '0;
    ce = 1'b1;
    miscompares = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    idle(6); // the line filter leaves reset at 00, so se0 reads 1 until idle j is through
    t_bits();
    t_attach();
    t_freeze();
    t_setup();
    t_power();
    conclude();
  end
endmodule
